//--- pkg/ufsu_params.svh
`ifndef UFSU_PARAMS_SVH
`define UFSU_PARAMS_SVH

// Register word offsets (byte addresses, bits [1:0] ignored)
`define UFSU_OFS_CFG      12'hd14
`define UFSU_OFS_FAULT    12'hd28
`define UFSU_OFS_PC       12'hd40
`define UFSU_OFS_IRQ_STAT 12'hd44
`define UFSU_OFS_IRQ_EN   12'hd48
`define UFSU_OFS_IRQ_CLR  12'hd4c

// Flag positions in the fault status word
`define UFSU_BIT_DIVZ  25
`define UFSU_BIT_UNAL  24
`define UFSU_RSV_HI    23
`define UFSU_RSV_LO    20
`define UFSU_BIT_COPR  19
`define UFSU_BIT_BADPC 18

// Trap enable positions in the configuration word
`define UFSU_CFG_DIVZ 4
`define UFSU_CFG_UNAL 3

// Index of each flag inside the internal flag vector
`define UFSU_F_DIVZ  3
`define UFSU_F_UNAL  2
`define UFSU_F_COPR  1
`define UFSU_F_BADPC 0

// Reset, fill and byte-strobe values
`define UFSU_WORD_ZERO 32'h0000_0000
`define UFSU_FLAGS_RST 4'h0
`define UFSU_CFG_RST   2'h0
`define UFSU_RSV_ZERO  4'h0
`define UFSU_LANE_HI   4'hc

`endif

//--- pkg/ufsu_pkg.sv
package ufsu_pkg;
    typedef logic [3:0]  ufsu_flags_t;
    typedef logic [31:0] ufsu_word_t;
    typedef logic [1:0]  ufsu_cfg_t;
endpackage

//--- logic/ufsu_sticky_bank.sv
`timescale 1ns/1ps
module ufsu_sticky_bank #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    // Set and clear strobes
    input  wire logic [WIDTH-1:0] i_set,
    input  wire logic [WIDTH-1:0] i_clr,
    // Held flags
    output logic      [WIDTH-1:0] o_flags
);
    logic [WIDTH-1:0] next_flags;

    if (WIDTH < 1) begin : g_bad_width
        $error("ufsu_sticky_bank: WIDTH must be at least 1");
    end

    // Set wins over a clear in the same cycle
    assign next_flags = (o_flags & ~i_clr) | i_set;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_flags <= '0;
        end else begin
            o_flags <= next_flags;
        end
    end
endmodule

//--- logic/ufsu_fault_qual.sv
`timescale 1ns/1ps
`include "ufsu_params.svh"
module ufsu_fault_qual #(
    parameter int PC_W = 32
) (
    // Clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_rst,
    // Core execution events
    input  wire logic                 i_div_exec,
    input  wire logic                 i_divisor_zero,
    input  wire logic                 i_mem_access,
    input  wire logic                 i_addr_unaligned,
    input  wire logic                 i_multi_or_double,
    input  wire logic                 i_coproc_access,
    input  wire logic                 i_bad_exception_return_code_load,
    input  wire logic [PC_W-1:0]      i_instr_pc,
    // Trap enables
    input  wire logic                 i_div_trap_en,
    input  wire logic                 i_unal_trap_en,
    // Qualified faults and faulting instruction address
    output ufsu_pkg::ufsu_flags_t     o_events,
    output logic      [PC_W-1:0]      o_pc
);
    ufsu_pkg::ufsu_flags_t next_events;
    wire                   div_fault;
    wire                   unal_fault;

    if (PC_W < 1) begin : g_bad_pc
        $error("ufsu_fault_qual: PC_W must be at least 1");
    end

    assign div_fault  = i_div_exec & i_divisor_zero & i_div_trap_en;
    // Multiple and doubleword transfers fault whatever the enable says
    assign unal_fault = i_mem_access & i_addr_unaligned
                        & (i_multi_or_double | i_unal_trap_en);

    always_comb begin
        next_events                = `UFSU_FLAGS_RST;
        next_events[`UFSU_F_DIVZ]  = div_fault;
        next_events[`UFSU_F_UNAL]  = unal_fault;
        next_events[`UFSU_F_COPR]  = i_coproc_access;
        next_events[`UFSU_F_BADPC] = i_bad_exception_return_code_load;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_events <= `UFSU_FLAGS_RST;
            o_pc     <= '0;
        end else begin
            o_events <= next_events;
            o_pc     <= i_instr_pc;
        end
    end
endmodule

//--- logic/ufsu_usage_fault.sv
// Notes on behaviour
// - Zero-divisor divide with divide trapping on sets status bit 25.
// - Divide flag stays zero without a fault or while trapping is off.
// - On divide fault the saved return address is the divide's address.
// - Zero divisor traps only when the divide trap enable is set.
// - Writing one clears a flag; writing zero leaves it unchanged.
// - Unaligned access with unaligned trapping on sets status bit 24.
// - Unaligned multiple or doubleword transfers always raise the fault.
// - Single word and halfword unaligned faults follow the trap enable.
// - Bits 23:20 are reserved and read zero; software preserves them.
// - Coprocessor access attempt sets status bit 19.
// - Illegal return-code load into the program counter sets bit 18.
// - On bad PC load the saved return address is that instruction's.
// - Flags are reachable as the upper halfword and as the full word.
// - The whole fault status register resets to zero.
`timescale 1ns/1ps
`include "ufsu_params.svh"
module ufsu_usage_fault #(
    parameter int ADDR_W = 12,
    parameter int PC_W   = 32
) (
    // Clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // Core execution events
    input  wire logic              i_div_exec,
    input  wire logic              i_divisor_zero,
    input  wire logic              i_mem_access,
    input  wire logic              i_addr_unaligned,
    input  wire logic              i_multi_or_double,
    input  wire logic              i_coproc_access,
    input  wire logic              i_bad_exception_return_code_load,
    input  wire logic [PC_W-1:0]   i_instr_pc,
    // Fault report to the core
    output logic                   o_usage_fault,
    output logic      [PC_W-1:0]   o_return_pc,
    // Interrupt
    output logic                   o_irq
);
    if (ADDR_W != 12) begin : g_bad_addr
        $error("ufsu_usage_fault: ADDR_W must be 12");
    end
    if (PC_W < 1 || PC_W > 32) begin : g_bad_pc
        $error("ufsu_usage_fault: PC_W must be 1 to 32");
    end

    // Flag vector placed into its register word
    function automatic ufsu_pkg::ufsu_word_t pack_flags(
        input ufsu_pkg::ufsu_flags_t f
    );
        ufsu_pkg::ufsu_word_t w;
        w                   = `UFSU_WORD_ZERO;
        w[`UFSU_BIT_DIVZ]   = f[`UFSU_F_DIVZ];
        w[`UFSU_BIT_UNAL]   = f[`UFSU_F_UNAL];
        w[`UFSU_BIT_COPR]   = f[`UFSU_F_COPR];
        w[`UFSU_BIT_BADPC]  = f[`UFSU_F_BADPC];
        return w;
    endfunction

    // Register word taken back into a flag vector
    function automatic ufsu_pkg::ufsu_flags_t unpack_flags(
        input ufsu_pkg::ufsu_word_t w
    );
        ufsu_pkg::ufsu_flags_t f;
        f                = `UFSU_FLAGS_RST;
        f[`UFSU_F_DIVZ]  = w[`UFSU_BIT_DIVZ];
        f[`UFSU_F_UNAL]  = w[`UFSU_BIT_UNAL];
        f[`UFSU_F_COPR]  = w[`UFSU_BIT_COPR];
        f[`UFSU_F_BADPC] = w[`UFSU_BIT_BADPC];
        return f;
    endfunction

    // Configuration and state
    ufsu_pkg::ufsu_cfg_t   cfg;
    ufsu_pkg::ufsu_cfg_t   next_cfg;
    ufsu_pkg::ufsu_flags_t irq_en;
    ufsu_pkg::ufsu_flags_t next_irq_en;
    ufsu_pkg::ufsu_flags_t fault_flags;
    ufsu_pkg::ufsu_flags_t irq_flags;
    ufsu_pkg::ufsu_flags_t events;
    logic [PC_W-1:0]       event_pc;
    logic [PC_W-1:0]       next_return_pc;
    logic [31:0]           next_prdata;
    logic [31:0]           cfg_word;

    // Decode
    wire        cfg_div_en;
    wire        cfg_unal_en;
    wire [11:0] word_addr;
    wire        sel_cfg;
    wire        sel_fault;
    wire        sel_pc;
    wire        sel_irq_stat;
    wire        sel_irq_en;
    wire        sel_irq_clr;
    wire        addr_hit;
    wire        access;
    wire        next_pready;
    wire        next_pslverr;
    wire        wr_fire;
    wire [31:0] lane_mask;
    wire [31:0] wr_bits;
    wire [31:0] fault_word;
    wire [31:0] irq_word;
    wire [31:0] irq_en_word;
    wire [31:0] pc_word;
    wire        any_event;

    ufsu_pkg::ufsu_flags_t fault_clr;
    ufsu_pkg::ufsu_flags_t irq_clr;

    assign cfg_div_en   = cfg[1];
    assign cfg_unal_en  = cfg[0];
    assign word_addr    = {i_paddr[11:2], 2'h0};
    assign sel_cfg      = word_addr == `UFSU_OFS_CFG;
    // Word at 0xd28 and upper halfword at 0xd2a share one word
    assign sel_fault    = word_addr == `UFSU_OFS_FAULT;
    assign sel_pc       = word_addr == `UFSU_OFS_PC;
    assign sel_irq_stat = word_addr == `UFSU_OFS_IRQ_STAT;
    assign sel_irq_en   = word_addr == `UFSU_OFS_IRQ_EN;
    assign sel_irq_clr  = word_addr == `UFSU_OFS_IRQ_CLR;
    assign addr_hit     = sel_cfg | sel_fault | sel_pc | sel_irq_stat
                          | sel_irq_en | sel_irq_clr;

    // One wait state: ready rises in the second access cycle
    assign access       = i_psel & i_penable;
    assign next_pready  = access & ~o_pready;
    assign next_pslverr = next_pready & ~addr_hit;
    assign wr_fire      = access & o_pready & i_pwrite & addr_hit;

    assign lane_mask    = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}},
                           {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
    assign wr_bits      = i_pwdata & lane_mask;

    // Write one to clear, byte lanes honoured
    assign fault_clr    = (wr_fire & sel_fault)
                          ? unpack_flags(wr_bits) : `UFSU_FLAGS_RST;
    assign irq_clr      = (wr_fire & sel_irq_clr)
                          ? unpack_flags(wr_bits) : `UFSU_FLAGS_RST;

    // Reserved bits 23:20 and all unused bits read zero
    assign fault_word   = pack_flags(fault_flags);
    assign irq_word     = pack_flags(irq_flags);
    assign irq_en_word  = pack_flags(irq_en);
    assign pc_word      = 32'(o_return_pc);

    always_comb begin
        cfg_word                 = `UFSU_WORD_ZERO;
        cfg_word[`UFSU_CFG_DIVZ] = cfg_div_en;
        cfg_word[`UFSU_CFG_UNAL] = cfg_unal_en;
    end

    assign next_prdata  = (~next_pready | i_pwrite) ? `UFSU_WORD_ZERO
                        : sel_fault    ? fault_word
                        : sel_cfg      ? cfg_word
                        : sel_pc       ? pc_word
                        : sel_irq_stat ? irq_word
                        : sel_irq_en   ? irq_en_word
                        : `UFSU_WORD_ZERO;

    always_comb begin
        next_cfg = cfg;
        if (wr_fire && sel_cfg && i_pstrb[0]) begin
            next_cfg = {i_pwdata[`UFSU_CFG_DIVZ], i_pwdata[`UFSU_CFG_UNAL]};
        end
    end

    assign next_irq_en = (wr_fire && sel_irq_en)
                         ? (unpack_flags(wr_bits)
                            | (irq_en & unpack_flags(~lane_mask)))
                         : irq_en;

    // Event qualification against the trap enables
    ufsu_fault_qual #(
        .PC_W                  (PC_W)
    ) u_qual (
        .i_core_clk            (i_core_clk),
        .i_rst                 (i_rst),
        .i_div_exec            (i_div_exec),
        .i_divisor_zero        (i_divisor_zero),
        .i_mem_access          (i_mem_access),
        .i_addr_unaligned      (i_addr_unaligned),
        .i_multi_or_double     (i_multi_or_double),
        .i_coproc_access       (i_coproc_access),
        .i_bad_exception_return_code_load (i_bad_exception_return_code_load),
        .i_instr_pc            (i_instr_pc),
        .i_div_trap_en         (cfg_div_en),
        .i_unal_trap_en        (cfg_unal_en),
        .o_events              (events),
        .o_pc                  (event_pc)
    );

    // Sticky fault flags, set beats clear
    ufsu_sticky_bank #(
        .WIDTH      (4)
    ) u_fault_flags (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_set      (events),
        .i_clr      (fault_clr),
        .o_flags    (fault_flags)
    );

    // Interrupt status with its own clear register
    ufsu_sticky_bank #(
        .WIDTH      (4)
    ) u_irq_flags (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_set      (events),
        .i_clr      (irq_clr),
        .o_flags    (irq_flags)
    );

    // Return address follows the faulting instruction
    assign any_event      = |events;
    assign next_return_pc = any_event ? event_pc : o_return_pc;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cfg <= `UFSU_CFG_RST;
            irq_en <= `UFSU_FLAGS_RST;
        end else begin
            cfg <= next_cfg;
            irq_en <= next_irq_en;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= `UFSU_WORD_ZERO;
        end else begin
            o_pready  <= next_pready;
            o_pslverr <= next_pslverr;
            o_prdata  <= next_prdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_usage_fault <= 1'b0;
            o_return_pc   <= '0;
            o_irq         <= 1'b0;
        end else begin
            o_usage_fault <= any_event;
            o_return_pc   <= next_return_pc;
            o_irq         <= |(next_irq_en & irq_flags);
        end
    end

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence seq_div_zero;
        i_div_exec && i_divisor_zero && cfg_div_en;
    endsequence

    sequence seq_unal_forced;
        i_mem_access && i_addr_unaligned && i_multi_or_double;
    endsequence

    sequence seq_div_clear;
        wr_fire && sel_fault && i_pstrb[3] && i_pwdata[`UFSU_BIT_DIVZ];
    endsequence

    chk_div_zero_set: assert property (
        seq_div_zero |-> ##2 fault_word[`UFSU_BIT_DIVZ])
        else $error("divide by zero flag not set");

    chk_div_flag_cause: assert property (
        $rose(fault_flags[`UFSU_F_DIVZ]) |-> $past(events[`UFSU_F_DIVZ]))
        else $error("divide flag rose without a fault");

    chk_div_return_pc: assert property (
        i_div_exec && i_divisor_zero && cfg_div_en
        |-> ##2 o_return_pc == $past(i_instr_pc, 2))
        else $error("return address wrong after divide fault");

    chk_div_trap_off: assert property (
        !cfg_div_en |=> !events[`UFSU_F_DIVZ])
        else $error("divide trapped while disabled");

    chk_write_zero_keeps: assert property (
        wr_fire && sel_fault && !i_pwdata[`UFSU_BIT_COPR]
        && fault_flags[`UFSU_F_COPR] |=> fault_flags[`UFSU_F_COPR])
        else $error("writing zero changed a flag");

    chk_unal_enabled: assert property (
        i_mem_access && i_addr_unaligned && cfg_unal_en
        |-> ##2 fault_word[`UFSU_BIT_UNAL])
        else $error("unaligned flag not set");

    chk_unal_forced: assert property (
        seq_unal_forced |-> ##2 fault_word[`UFSU_BIT_UNAL])
        else $error("multiple or double unaligned not flagged");

    chk_unal_single_off: assert property (
        i_mem_access && i_addr_unaligned && !i_multi_or_double
        && !cfg_unal_en |=> !events[`UFSU_F_UNAL])
        else $error("single unaligned trapped while disabled");

    chk_reserved_zero: assert property (
        access && !o_pready && !i_pwrite && sel_fault
        |=> o_prdata[`UFSU_RSV_HI:`UFSU_RSV_LO] == `UFSU_RSV_ZERO)
        else $error("reserved bits read nonzero");

    chk_coproc_set: assert property (
        i_coproc_access |-> ##2 fault_word[`UFSU_BIT_COPR])
        else $error("coprocessor flag not set");

    chk_bad_pc_set: assert property (
        i_bad_exception_return_code_load
        |-> ##2 (o_usage_fault && fault_word[`UFSU_BIT_BADPC]))
        else $error("bad pc load flag not set");

    chk_bad_pc_return: assert property (
        i_bad_exception_return_code_load |-> ##2 o_return_pc == $past(i_instr_pc, 2))
        else $error("return address wrong after bad pc load");

    chk_half_clear: assert property (
        seq_div_clear and (i_pstrb == `UFSU_LANE_HI)
        && !events[`UFSU_F_DIVZ] |=> !fault_flags[`UFSU_F_DIVZ])
        else $error("upper halfword clear failed");

    chk_reset_zero: assert property (
        $fell(i_rst) |-> fault_word == `UFSU_WORD_ZERO)
        else $error("fault status not zero after reset");

    chk_set_beats_clear: assert property (
        seq_div_clear and events[`UFSU_F_DIVZ]
        |=> fault_flags[`UFSU_F_DIVZ])
        else $error("clear won over a new fault");
endmodule

//--- testbench/ufsu_core_model.sv
`timescale 1ns/1ps
module ufsu_core_model (
    // Clock
    input  wire logic        i_core_clk,
    // Core execution events
    output logic             o_div_exec,
    output logic             o_divisor_zero,
    output logic             o_mem_access,
    output logic             o_addr_unaligned,
    output logic             o_multi_or_double,
    output logic             o_coproc_access,
    output logic             o_bad_exception_return_code_load,
    output logic      [31:0] o_instr_pc
);
    initial begin
        {o_div_exec, o_divisor_zero, o_mem_access, o_addr_unaligned} = 4'h0;
        {o_multi_or_double, o_coproc_access, o_bad_exception_return_code_load} = 3'h0;
        o_instr_pc = 32'h0000_0000;
    end

    // Kinds: 0 zero divide, 1 divide, 2 single unaligned, 3 multiple
    // unaligned, 4 coprocessor, 5 bad return load; held for n cycles
    task automatic fire(input int kind, input logic [31:0] pc, input int n);
        @(posedge i_core_clk);
        o_div_exec            <= (kind < 2);
        o_divisor_zero        <= (kind == 0);
        o_mem_access          <= (kind == 2) || (kind == 3);
        o_addr_unaligned      <= (kind == 2) || (kind == 3);
        o_multi_or_double     <= (kind == 3);
        o_coproc_access       <= (kind == 4);
        o_bad_exception_return_code_load <= (kind == 5);
        o_instr_pc            <= pc;
        repeat (n) @(posedge i_core_clk);
        {o_div_exec, o_divisor_zero, o_mem_access, o_addr_unaligned} <= 4'h0;
        {o_multi_or_double, o_coproc_access, o_bad_exception_return_code_load} <= 3'h0;
        // Address bus does not keep the last value once idle
        o_instr_pc            <= ~pc;
    endtask
endmodule

//--- testbench/usage_fault_status_upper_bench.sv
`timescale 1ns/1ps
module usage_fault_status_upper_bench;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        dx, dz, ma, au, md, cp, bl;
    logic [31:0] ipc;
    logic        usage_fault;
    logic [31:0] return_pc;
    logic        irq;
    int          err_count;
    int          n_checks;

    ufsu_usage_fault u_ufsu_usage_fault (
        .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_div_exec(dx), .i_divisor_zero(dz),
        .i_mem_access(ma), .i_addr_unaligned(au), .i_multi_or_double(md),
        .i_coproc_access(cp), .i_bad_exception_return_code_load(bl),
        .i_instr_pc(ipc), .o_usage_fault(usage_fault),
        .o_return_pc(return_pc), .o_irq(irq));

    ufsu_core_model u_ufsu_core_model (
        .i_core_clk(clk), .o_div_exec(dx), .o_divisor_zero(dz),
        .o_mem_access(ma), .o_addr_unaligned(au), .o_multi_or_double(md),
        .o_coproc_access(cp), .o_bad_exception_return_code_load(bl),
        .o_instr_pc(ipc));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input string nm);
        logic [31:0] r;
        logic        er;
        apb(1'b0, a, 32'h0000_0000, 4'hf, r, er);
        chk(nm, e, r);
        chk({nm, " err"}, 32'h0000_0000, {31'h0, er});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic [31:0] r;
        logic        er;
        apb(1'b1, a, d, s, r, er);
        chk("write err", 32'h0000_0000, {31'h0, er});
    endtask

    task automatic ev(input int k, input logic [31:0] pc, input logic f,
                      input string nm);
        u_ufsu_core_model.fire(k, pc, 1);
        // Fault pulse and return address appear two edges after the event
        @(posedge clk);
        #1;
        chk({nm, " fault"}, {31'h0, f}, {31'h0, usage_fault});
        if (f) begin
            chk({nm, " pc"}, pc, return_pc);
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset();
        rd(12'hd28, 32'h0000_0000, "fault rst");
        rd(12'hd14, 32'h0000_0000, "cfg rst");
        chk("irq rst", 32'h0000_0000, {31'h0, irq});
        $display("test reset done");
    endtask

    task automatic t_div();
        ev(0, 32'h0000_1000, 1'b0, "div off");
        rd(12'hd28, 32'h0000_0000, "div off flag");
        wr(12'hd14, 32'h0000_0010, 4'h1);
        ev(1, 32'h0000_1004, 1'b0, "div nz");
        ev(0, 32'h0000_1008, 1'b1, "div zero");
        rd(12'hd28, 32'h0200_0000, "div flag");
        $display("test divide done");
    endtask

    task automatic t_unal();
        wr(12'hd14, 32'h0000_0000, 4'h1);
        ev(2, 32'h0000_2000, 1'b0, "unal off");
        ev(3, 32'h0000_2004, 1'b1, "multi");
        rd(12'hd28, 32'h0300_0000, "multi flag");
        wr(12'hd28, 32'h0100_0000, 4'hf);
        rd(12'hd28, 32'h0200_0000, "unal clr");
        wr(12'hd14, 32'h0000_0008, 4'h1);
        ev(2, 32'h0000_2008, 1'b1, "unal on");
        rd(12'hd28, 32'h0300_0000, "unal flag");
        $display("test unaligned done");
    endtask

    task automatic t_cop_pc();
        ev(4, 32'h0000_3000, 1'b1, "coproc");
        ev(5, 32'h0000_3004, 1'b1, "bad pc");
        rd(12'hd28, 32'h030c_0000, "all flags");
        $display("test coproc done");
    endtask

    task automatic t_clear();
        wr(12'hd28, 32'h0000_0000, 4'hf);
        rd(12'hd28, 32'h030c_0000, "zero write");
        wr(12'hd2a, 32'h0208_0000, 4'hc);
        rd(12'hd28, 32'h0104_0000, "half clr");
        wr(12'hd28, 32'hffff_ffff, 4'h3);
        rd(12'hd28, 32'h0104_0000, "low lanes");
        wr(12'hd28, 32'hffff_ffff, 4'hf);
        rd(12'hd28, 32'h0000_0000, "all clr");
        $display("test clear done");
    endtask

    task automatic t_race();
        wr(12'hd14, 32'h0000_0010, 4'h1);
        // Last divide event meets the clearing write at the same edge
        fork
            u_ufsu_core_model.fire(0, 32'h0000_4000, 2);
            wr(12'hd28, 32'h0200_0000, 4'hf);
        join
        repeat (2) @(posedge clk);
        rd(12'hd28, 32'h0200_0000, "set wins");
        $display("test race done");
    endtask

    task automatic t_irq();
        wr(12'hd4c, 32'hffff_ffff, 4'hf);
        rd(12'hd44, 32'h0000_0000, "irq stat clr");
        wr(12'hd48, 32'h0008_0000, 4'hf);
        ev(4, 32'h0000_5000, 1'b1, "irq cop");
        repeat (3) @(posedge clk);
        chk("irq on", 32'h0000_0001, {31'h0, irq});
        wr(12'hd48, 32'h0000_0000, 4'hf);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        wr(12'hd48, 32'h0008_0000, 4'hf);
        repeat (2) @(posedge clk);
        chk("irq unmask", 32'h0000_0001, {31'h0, irq});
        wr(12'hd4c, 32'h0008_0000, 4'hf);
        repeat (2) @(posedge clk);
        chk("irq clr", 32'h0000_0000, {31'h0, irq});
        rd(12'hd44, 32'h0000_0000, "irq stat");
        $display("test irq done");
    endtask

    task automatic t_unmapped();
        logic [31:0] r;
        logic        er;
        apb(1'b0, 12'hd00, 32'h0000_0000, 4'hf, r, er);
        chk("unmapped err", 32'h0000_0001, {31'h0, er});
        chk("unmapped data", 32'h0000_0000, r);
        $display("test unmapped done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    initial begin
        err_count = 0;
        n_checks = 0;
        rst = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_div();
        t_unal();
        t_cop_pc();
        t_clear();
        t_race();
        t_irq();
        t_unmapped();
        give_verdict();
    end
endmodule
